// >>> rpoc_consts.vh
// Constants of the receive overhead and clock port block.
`ifndef RPOC_CONSTS_VH
`define RPOC_CONSTS_VH

// Register byte offsets on the APB.
`define RPOC_CTRL_ADDR      12'h000
`define RPOC_STAT_ADDR      12'h004

// Control register field positions.
`define RPOC_MODE_LSB       0
`define RPOC_MODE_MSB       2
`define RPOC_PINS_EN_BIT    3
`define RPOC_CLK_SEL_BIT    4
`define RPOC_INV_OHDAT_BIT  5
`define RPOC_INV_RCLK_BIT   6
`define RPOC_INV_GCLK_BIT   7
`define RPOC_INV_OHCLK_BIT  8
`define RPOC_CTRL_MASK      32'h0000_01ff
`define RPOC_CTRL_RESET     32'h0000_0000

// Framing modes.
`define RPOC_MODE_DS3       3'h0
`define RPOC_MODE_E3        3'h1
`define RPOC_MODE_DS3_PLCP  3'h2
`define RPOC_MODE_E3_PLCP   3'h3
`define RPOC_MODE_CC52      3'h4
`define RPOC_MODE_EXT_FRAC  3'h5
`define RPOC_MODE_INT_FRAC  3'h6
`define RPOC_MODE_FLEX_FRAC 3'h7

// Shared clock pin functions.
`define RPOC_FN_NONE        2'h0
`define RPOC_FN_RCLK        2'h1
`define RPOC_FN_GCLK        2'h2
`define RPOC_FN_OHCLK       2'h3

// Framer rising edges per half period of the overhead clock.
`define RPOC_OH_HALF_DIV    8
// Overhead FIFO geometry: bit plus start flag, eight entries.
`define RPOC_FIFO_WIDTH     2
`define RPOC_FIFO_DEPTH     8

`endif

// >>> rpoc_port.v
// Receive overhead port, shared clock pin and its overhead FIFO.
`timescale 1ns/1ns
`include "rpoc_consts.vh"

module rpoc_fifo #(
    parameter WIDTH = `RPOC_FIFO_WIDTH,
    parameter DEPTH = `RPOC_FIFO_DEPTH,
    parameter AW    = 3
) (
    // Clock and control.
    input  wire             mclk,
    input  wire             rst,
    input  wire             ce,
    // Fill side.
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side.
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // Fill level.
    output wire [AW:0]      level
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wr_ff;
    reg [AW-1:0]    rd_ff;
    reg [AW:0]      cnt_ff;
    wire            push;
    wire            pop;
    genvar          gi;

    assign in_ready  = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_ff[rd_ff];
    assign level     = cnt_ff;

    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
            always @(posedge mclk) begin
                if (ce && push && wr_ff == gi[AW-1:0]) begin
                    mem_ff[gi] <= in_data;
                end
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (rst) begin
            wr_ff  <= {AW{1'b0}};
            rd_ff  <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // rpoc_fifo

module rpoc_port #(
    parameter OH_HALF_DIV = `RPOC_OH_HALF_DIV
) (
    // Clock, reset and clock enable.
    input  wire        mclk,
    input  wire        rst,
    input  wire        ce,
    // APB register slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Internal receive framer clock and its per-bit qualifiers.
    input  wire        rx_framer_clk,
    input  wire        rx_bit_is_overhead,
    input  wire        rx_frac_oh_en_in,
    // Overhead bit stream from the PLCP framer.
    input  wire        oh_in_valid,
    output wire        oh_in_ready,
    input  wire        oh_in_bit,
    input  wire        oh_in_first,
    // Port pins.
    output reg         rx_clk_pin,
    output reg         rx_overhead_data_out,
    output reg         rx_overhead_start_marker,
    output reg         rx_payload_data_enable,
    output reg         rx_fractional_overhead_enable_out
);
    reg  [31:0] ctrl_ff;
    reg  [2:0]  fclk_sync_ff;
    reg         ovh_s1_ff;
    reg         ovh_s2_ff;
    reg         frac_s1_ff;
    reg         frac_s2_ff;
    reg  [7:0]  div_cnt_ff;
    reg         ohclk_ff;
    reg  [1:0]  fn_ff;
    reg  [1:0]  nxt_fn;
    reg         nxt_pin;
    wire        fclk;
    wire        fclk_rise;
    wire [2:0]  mode;
    wire        pins_en;
    wire        clk_sel_gated;
    wire        plcp_mode;
    wire        ext_timing;
    wire        plain_framed;
    wire        gate_en;
    wire        oh_fall;
    reg         oh_fall_ff;
    wire        oh_shift;
    wire        fifo_valid;
    wire [1:0]  fifo_data;
    wire [3:0]  fifo_level;
    wire        apb_wr;
    wire        apb_rd;
    wire        addr_ok;

    assign mode          = ctrl_ff[`RPOC_MODE_MSB:`RPOC_MODE_LSB];
    assign pins_en       = ctrl_ff[`RPOC_PINS_EN_BIT];
    assign clk_sel_gated = ctrl_ff[`RPOC_CLK_SEL_BIT];
    assign plcp_mode     = (mode == `RPOC_MODE_DS3_PLCP) ||
                           (mode == `RPOC_MODE_E3_PLCP);
    assign ext_timing    = (mode == `RPOC_MODE_EXT_FRAC) ||
                           (mode == `RPOC_MODE_FLEX_FRAC);
    assign plain_framed  = (mode == `RPOC_MODE_DS3) ||
                           (mode == `RPOC_MODE_E3);

    // The registers answer in the access cycle, so pready is tied high.
    assign pready  = 1'b1;
    assign addr_ok = (paddr == `RPOC_CTRL_ADDR) ||
                     (paddr == `RPOC_STAT_ADDR);
    assign pslverr = psel & penable & ~addr_ok;
    assign apb_wr  = psel & penable & pwrite;
    assign apb_rd  = psel & ~penable & ~pwrite;

    always @(posedge mclk) begin
        if (rst) begin
            ctrl_ff <= `RPOC_CTRL_RESET;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            if (apb_wr && paddr == `RPOC_CTRL_ADDR) begin
                ctrl_ff <= pwdata & `RPOC_CTRL_MASK;
            end
            // Read data is loaded in the setup cycle and stands in access.
            if (apb_rd) begin
                case (paddr)
                    `RPOC_CTRL_ADDR: prdata <= ctrl_ff;
                    `RPOC_STAT_ADDR: prdata <= {24'h00_0000, fn_ff, ohclk_ff,
                                                1'b0, fifo_level};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // The framer clock arrives from another domain; stage 0 feeds only
    // stage 1, and the edge detector looks at stages 1 and 2 alone.
    // The copy lags by one to two system cycles and its edges are
    // quantised to the system clock, which bounds the usable line rate.
    always @(posedge mclk) begin
        if (rst) begin
            fclk_sync_ff <= 3'h0;
            ovh_s1_ff    <= 1'b0;
            ovh_s2_ff    <= 1'b0;
            frac_s1_ff   <= 1'b0;
            frac_s2_ff   <= 1'b0;
        end else if (ce) begin
            fclk_sync_ff <= {fclk_sync_ff[1:0], rx_framer_clk};
            ovh_s1_ff    <= rx_bit_is_overhead;
            ovh_s2_ff    <= ovh_s1_ff;
            frac_s1_ff   <= rx_frac_oh_en_in;
            frac_s2_ff   <= frac_s1_ff;
        end
    end

    assign fclk      = fclk_sync_ff[1];
    assign fclk_rise = fclk_sync_ff[1] & ~fclk_sync_ff[2];

    // Bit qualifiers are taken once per framer bit, on its rising edge.
    always @(posedge mclk) begin
        if (rst) begin
            rx_payload_data_enable            <= 1'b0;
            rx_fractional_overhead_enable_out <= 1'b0;
        end else if (ce && fclk_rise) begin
            rx_payload_data_enable            <= ~ovh_s2_ff;
            rx_fractional_overhead_enable_out <= frac_s2_ff;
        end
    end

    // Internal fractional mode gates on the fractional overhead enable.
    assign gate_en = (mode == `RPOC_MODE_INT_FRAC) ?
                     rx_fractional_overhead_enable_out :
                     rx_payload_data_enable;

    // Overhead clock: a divider on framer edges, held low outside PLCP.
    always @(posedge mclk) begin
        if (rst) begin
            div_cnt_ff <= 8'h00;
            ohclk_ff   <= 1'b0;
        end else if (ce) begin
            if (!(plcp_mode && pins_en)) begin
                div_cnt_ff <= 8'h00;
                ohclk_ff   <= 1'b0;
            end else if (fclk_rise) begin
                if (div_cnt_ff == OH_HALF_DIV[7:0] - 8'h01) begin
                    div_cnt_ff <= 8'h00;
                    ohclk_ff   <= ~ohclk_ff;
                end else begin
                    div_cnt_ff <= div_cnt_ff + 8'h01;
                end
            end
        end
    end

    assign oh_fall = ohclk_ff & fclk_rise & plcp_mode & pins_en &
                     (div_cnt_ff == OH_HALF_DIV[7:0] - 8'h01);

    // The pin copies the divider one cycle late, so the pop waits a cycle
    // and data move on the very edge at which the pin itself falls.
    always @(posedge mclk) begin
        if (rst) begin
            oh_fall_ff <= 1'b0;
        end else if (ce) begin
            oh_fall_ff <= oh_fall;
        end
    end

    assign oh_shift = oh_fall_ff & plcp_mode & pins_en;

    // One overhead bit leaves the FIFO per falling overhead clock edge,
    // so the FIFO fills and stalls the PLCP framer through oh_in_ready.
    rpoc_fifo #(
        .WIDTH (`RPOC_FIFO_WIDTH),
        .DEPTH (`RPOC_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (oh_in_valid),
        .in_ready  (oh_in_ready),
        .in_data   ({oh_in_first, oh_in_bit}),
        .out_valid (fifo_valid),
        .out_ready (oh_shift),
        .out_data  (fifo_data),
        .level     (fifo_level)
    );

    // Data and marker move with the falling edge so that the far end,
    // which samples on the rising edge, sees half a period of setup.
    // An empty FIFO repeats the last bit with the marker low.
    always @(posedge mclk) begin
        if (rst) begin
            rx_overhead_data_out     <= 1'b0;
            rx_overhead_start_marker <= 1'b0;
        end else if (ce && oh_shift) begin
            if (fifo_valid) begin
                rx_overhead_data_out     <= fifo_data[0] ^
                    ctrl_ff[`RPOC_INV_OHDAT_BIT];
                rx_overhead_start_marker <= fifo_data[1];
            end else begin
                rx_overhead_start_marker <= 1'b0;
            end
        end
    end

    // Pin function by mode and selection, PLCP taking precedence.
    always @* begin
        nxt_fn = `RPOC_FN_NONE;
        if (plcp_mode && pins_en) begin
            nxt_fn = `RPOC_FN_OHCLK;
        end else if (clk_sel_gated) begin
            if (pins_en && ((mode == `RPOC_MODE_INT_FRAC) || plain_framed)) begin
                nxt_fn = `RPOC_FN_GCLK;
            end
        end else if (ext_timing || pins_en) begin
            nxt_fn = `RPOC_FN_RCLK;
        end
    end

    always @* begin
        case (nxt_fn)
            // The ungated copy follows the framer clock, so its rate is
            // that of the mode the framer clock runs at.
            `RPOC_FN_RCLK:  nxt_pin = fclk ^
                ctrl_ff[`RPOC_INV_RCLK_BIT];
            `RPOC_FN_GCLK:  nxt_pin = (fclk & gate_en) ^
                ctrl_ff[`RPOC_INV_GCLK_BIT];
            `RPOC_FN_OHCLK: nxt_pin = ohclk_ff ^
                ctrl_ff[`RPOC_INV_OHCLK_BIT];
            default:        nxt_pin = 1'b0;
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            fn_ff      <= `RPOC_FN_NONE;
            rx_clk_pin <= 1'b0;
        end else if (ce) begin
            fn_ff      <= nxt_fn;
            rx_clk_pin <= nxt_pin;
        end
    end
endmodule // rpoc_port

// >>> rpoc_port_bench.sv
// Self-checking bench of the overhead port and the shared clock pin.
`timescale 1ns/1ns
`include "rpoc_consts.vh"
module rpoc_port_bench;
    localparam [11:0]  AC = `RPOC_CTRL_ADDR;
    localparam [11:0]  AS = `RPOC_STAT_ADDR;
    // Rows of {pin function, control word}.
    localparam [167:0] ROWS = {12'h000, 12'h205, 12'h207, 12'h20c,
        12'h209, 12'h418, 12'h41e, 12'h419, 12'h01c, 12'h60a, 12'h60b,
        12'h002, 12'h015, 12'h20e};
    reg         mclk = 1'b0, rst = 1'b1, fclk = 1'b0, ovh = 1'b0;
    reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frac = 1'b0;
    reg         ovalid = 1'b0, obit = 1'b0, ofirst = 1'b0, er, ce = 1'b1;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0, rd;
    reg  [1:0]  fdiv = 2'h0;
    reg  [1:0]  capq [$];
    wire [31:0] prdata;
    wire        pready, pslverr, oready, pin, odat, omark, pden, foe;
    wire        cstb, cbit, cmark;
    integer     bad_count = 0, num_checks = 0, i, n;
    rpoc_port #(.OH_HALF_DIV(2)) dut (.mclk(mclk), .rst(rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_framer_clk(fclk), .rx_bit_is_overhead(ovh),
        .rx_frac_oh_en_in(frac), .oh_in_valid(ovalid), .oh_in_ready(oready),
        .oh_in_bit(obit), .oh_in_first(ofirst), .rx_clk_pin(pin),
        .rx_overhead_data_out(odat), .rx_overhead_start_marker(omark),
        .rx_payload_data_enable(pden),
        .rx_fractional_overhead_enable_out(foe));
    rpoc_sink u_sink (.mclk(mclk), .rst(rst), .ohclk(pin), .ohdat(odat),
        .ohmark(omark), .cap_stb_ff(cstb), .cap_bit_ff(cbit),
        .cap_mark_ff(cmark));
    always #4 mclk = ~mclk;
    // Framer clock of 64 ns, made on mclk so inputs move after the edge.
    always @(posedge mclk) begin
        fdiv <= fdiv + 2'h1;
        if (fdiv == 2'h3) fclk <= ~fclk;
    end
    always @(posedge mclk) if (cstb === 1'b1) capq.push_back({cmark, cbit});
    task test_done;
        begin
            if (bad_count == 0 && num_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task hang;
        begin
            bad_count = bad_count + 1;
            test_done;
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            // An idle cycle first, so psel is never lowered and raised in
            // one time step by two calls in a row.
            @(posedge mclk);
            psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            n = 0;
            @(posedge mclk);
            while (pready !== 1'b1 && n < 100) begin
                n = n + 1;
                @(posedge mclk);
            end
            if (n == 100) hang;
            rd = prdata;
            er = pslverr;
            psel <= 1'b0; penable <= 1'b0;
        end
    endtask
    task run(input integer c);
        repeat (c) @(posedge mclk);
    endtask
    initial begin
        run(8);
        rst <= 1'b0;
        run(1);
        apb(0, AC, 0); chk(rd, `RPOC_CTRL_RESET);
        apb(0, AS, 0); chk(rd, 0);
        for (i = 0; i < 14; i = i + 1) begin
            apb(1, AC, {23'h7fffff, ROWS[i*12 +: 9]});
            run(8);
            apb(0, AS, 0); chk(rd[7:6], ROWS[i*12+9 +: 2]);
            apb(0, AC, 0); chk(rd, ROWS[i*12 +: 9]);
            run(40);
        end
        apb(1, AC, 32'h018);
        apb(1, 12'h008, 32'h1); chk(er, 1);
        apb(0, 12'h008, 0); chk(er, 1); chk(rd, 0);
        apb(1, AS, 32'hff); apb(0, AC, 0); chk(rd, 32'h018);
        ovh <= 1'b1; run(20); chk({pden, pin}, 0);
        apb(1, AC, 32'h098); run(20); chk(pin, 1);
        ovh <= 1'b0; run(20); chk(pden, 1);
        apb(1, AC, 32'h01e); run(20); chk({foe, pin}, 0);
        frac <= 1'b1; run(40); chk(foe, 1);
        // Fill with the port off, so the ninth entry must wait.
        apb(1, AC, 0);
        for (i = 0; i < 9; i = i + 1) begin
            ovalid <= 1'b1; obit <= ^i[1:0]; ofirst <= (i == 0);
            if (i == 8) begin
                run(4); chk(oready, 0);
                apb(0, AS, 0); chk(rd[3:0], 8);
                apb(1, AC, 32'h00a);
            end
            // Ready is judged mid-cycle, where it has settled.
            n = 0;
            @(negedge mclk);
            while (oready !== 1'b1 && n < 2000) begin
                n = n + 1;
                @(negedge mclk);
            end
            if (n == 2000) hang;
            @(posedge mclk);
        end
        ovalid <= 1'b0;
        n = 0;
        while (capq.size() < 9 && n < 3000) begin
            n = n + 1;
            @(posedge mclk);
        end
        if (n == 3000) hang;
        for (i = 0; i < 9; i = i + 1)
            chk(capq[i], {i == 0, ^i[1:0]});
        run(40); chk({omark, odat}, 0);
        apb(0, AS, 0); chk(rd[3:0], 0);
        // An empty FIFO holds the data, so the inverted bit needs an entry.
        apb(1, AC, 32'h02a);
        ovalid <= 1'b1; obit <= 1'b0; ofirst <= 1'b0;
        run(1); ovalid <= 1'b0;
        run(80); chk(odat, 1);
        // Clock enable low freezes the pin and refuses register writes.
        ce <= 1'b0; run(2); rd = {31'h0, pin};
        run(20); chk(pin, rd);
        apb(1, AC, 32'h000); ce <= 1'b1;
        apb(0, AC, 0); chk(rd, 32'h02a);
        // A second reset in mid-run brings every output back to rest.
        rst <= 1'b1; run(4); rst <= 1'b0; run(1);
        chk({pin, odat, omark, pden, foe, oready}, 6'h01);
        apb(0, AC, 0); chk(rd, `RPOC_CTRL_RESET);
        test_done;
    end
endmodule // rpoc_port_bench

// >>> rpoc_port_sva.sv
// Checker of the overhead port and the shared clock pin.
`timescale 1ns/1ns
`include "rpoc_consts.vh"
module rpoc_port_sva #(
    parameter OH_HALF_DIV = 8
) (
    // Clock, reset and APB.
    input wire        mclk,
    input wire        rst,
    input wire        ce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // Port pins.
    input wire        rx_clk_pin,
    input wire        rx_overhead_data_out,
    input wire        rx_overhead_start_marker,
    input wire        rx_payload_data_enable,
    input wire        rx_fractional_overhead_enable_out
);
    // Overhead half period in mclk cycles, framer clock of 8 mclk assumed.
    localparam int OH_MAX = 8 * OH_HALF_DIV + 4;
    reg  [8:0] ctrl_ff;
    reg  [2:0] age_ff;
    wire [2:0] md   = ctrl_ff[2:0];
    wire       old  = age_ff == 3'h7;
    wire       plcp = (md == 3'h2 || md == 3'h3) && ctrl_ff[3];
    wire       rclk = !plcp && !ctrl_ff[4]
                      && (md == 3'h5 || md == 3'h7 || ctrl_ff[3]);
    wire       gclk = !plcp && ctrl_ff[4] && ctrl_ff[3]
                      && (md == 3'h6 || md < 3'h2);
    wire       gate = (md == 3'h6) ? rx_fractional_overhead_enable_out
                                   : rx_payload_data_enable;
    // Age keeps assertions quiet while the pin settles after a new setting.
    always @(posedge mclk) begin
        if (rst && ce) begin
            ctrl_ff <= 9'h000;
            age_ff  <= 3'h0;
        end else if (ce && psel && penable && pwrite
                     && paddr == `RPOC_CTRL_ADDR) begin
            ctrl_ff <= pwdata[8:0];
            age_ff  <= 3'h0;
        end else if (ce && !old) begin
            age_ff  <= age_ff + 3'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    // A frozen block neither moves nor is judged.
    default disable iff (rst || !ce);
    property p_data_fall;
        old && $changed(rx_overhead_data_out) |-> plcp
            && $changed(rx_clk_pin) && rx_clk_pin == ctrl_ff[8];
    endproperty
    a_data_fall: assert property (p_data_fall)
        else $error("overhead data moved off the clock fall");
    property p_mark_fall;
        old && $changed(rx_overhead_start_marker) |-> plcp
            && $changed(rx_clk_pin) && rx_clk_pin == ctrl_ff[8];
    endproperty
    a_mark_fall: assert property (p_mark_fall)
        else $error("start marker moved off the clock fall");
    property p_idle;
        old && !plcp && !rclk && !gclk |-> !rx_clk_pin;
    endproperty
    a_idle: assert property (p_idle)
        else $error("clock pin not idle low");
    property p_rclk_run;
        old && rclk |-> ##[1:6] ($changed(rx_clk_pin) || !old);
    endproperty
    a_rclk_run: assert property (p_rclk_run)
        else $error("framer clock copy stopped");
    property p_gclk_shut;
        old && gclk && !gate && !$past(gate) && !$past(gate, 2)
            |-> rx_clk_pin == ctrl_ff[7];
    endproperty
    a_gclk_shut: assert property (p_gclk_shut)
        else $error("gated clock passed while enable low");
    property p_gclk_pass;
        old && gclk && gate |-> ##[1:6] ($changed(rx_clk_pin) || !old || !gate);
    endproperty
    a_gclk_pass: assert property (p_gclk_pass)
        else $error("gated clock blocked while enable high");
    property p_oh_slow;
        old && plcp && $changed(rx_clk_pin)
            |=> ($stable(rx_clk_pin) || !old) [*8];
    endproperty
    a_oh_slow: assert property (p_oh_slow)
        else $error("overhead clock too fast");
    property p_oh_run;
        old && plcp |-> ##[1:OH_MAX] ($changed(rx_clk_pin) || !old);
    endproperty
    a_oh_run: assert property (p_oh_run)
        else $error("overhead clock stopped");
endmodule // rpoc_port_sva

bind rpoc_port rpoc_port_sva #(.OH_HALF_DIV(OH_HALF_DIV)) u_sva (
    .mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .rx_clk_pin(rx_clk_pin), .rx_overhead_data_out(rx_overhead_data_out),
    .rx_overhead_start_marker(rx_overhead_start_marker),
    .rx_payload_data_enable(rx_payload_data_enable),
    .rx_fractional_overhead_enable_out(rx_fractional_overhead_enable_out));

// >>> rpoc_sink.sv
// Receiving logic that captures the overhead port on its clock rise.
`timescale 1ns/1ns
module rpoc_sink (
    // Clock and reset.
    input  wire mclk,
    input  wire rst,
    // Overhead port pins.
    input  wire ohclk,
    input  wire ohdat,
    input  wire ohmark,
    // One strobe per captured bit, from the marker on.
    output reg  cap_stb_ff,
    output reg  cap_bit_ff,
    output reg  cap_mark_ff
);
    reg clk_ff;
    reg lock_ff;
    always @(posedge mclk) begin
        clk_ff     <= ohclk;
        cap_stb_ff <= 1'b0;
        if (rst) begin
            lock_ff <= 1'b0;
        end else if (ohclk && !clk_ff) begin
            // Bits before the first marker are not framed yet.
            lock_ff     <= lock_ff | ohmark;
            cap_stb_ff  <= lock_ff | ohmark;
            cap_bit_ff  <= ohdat;
            cap_mark_ff <= ohmark;
        end
    end
endmodule // rpoc_sink
